// file: core/wdt_regs.vh
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// register offsets on the plain register port
`define WDT_OFS_KEY        8'h00
`define WDT_OFS_COUNT      8'h04
`define WDT_OFS_STATUS     8'h08
`define WDT_OFS_CONTROL    8'h0C
`define WDT_OFS_OPTION     8'h10

// refresh key value
`define WDT_KEY_VALUE      8'hAC

// option byte field positions
`define WDT_OPT_RUN_BIT    4
`define WDT_OPT_WIN_HI     6
`define WDT_OPT_WIN_LO     5
`define WDT_OPT_OVF_HI     3
`define WDT_OPT_OVF_LO     1
`define WDT_OPT_STBY_BIT   0

// window select codes
`define WDT_WIN_50         2'h1
`define WDT_WIN_75         2'h2
`define WDT_WIN_100        2'h3

// overflow limits, slow clock periods, codes 0 to 7
`define WDT_OVF_LIM0       17'h00040
`define WDT_OVF_LIM1       17'h00080
`define WDT_OVF_LIM2       17'h00100
`define WDT_OVF_LIM3       17'h00200
`define WDT_OVF_LIM4       17'h00800
`define WDT_OVF_LIM5       17'h02000
`define WDT_OVF_LIM6       17'h04000
`define WDT_OVF_LIM7       17'h10000

// status bit positions
`define WDT_ST_RUNNING     0
`define WDT_ST_WIN_OPEN    1
`define WDT_ST_ABNORMAL    2
`define WDT_ST_OVERFLOW    3
`define WDT_ST_INTERVAL    4

// control bit positions and reset values
`define WDT_CTL_IRQ_EN     0
`define WDT_CTL_RESET      8'h00
`define WDT_CTL_IRQ_RST    1'b0

// nominal slow oscillator rate in Hz
`define WDT_SLOW_HZ        15000

`endif

// file: core/wdt_sync.v
`timescale 1ns/10ps
module wdt_sync (
   input  wire clock,
   input  wire rst_b,
   input  wire async_in,
   output reg  sync_out
);
   reg stage1;

   always @(posedge clock) begin
      if (!rst_b) begin
         stage1   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end
endmodule // wdt_sync

// file: core/wdt_watchdog.v
//
// Operation
// - counter advances on the slow oscillator clock, not on the system clock
// - counter runs only when option run enable bit 4 is 1
// - overflow time selectable: 2^6,7,8,9,11,13,14,16 slow periods
// - interval interrupt at 75% of overflow time plus half slow period
// - open window is final 50%, 75% or 100% of each period
// - key AC written in open window clears counter, counting resumes
// - key written in closed window flags abnormality and requests reset
// - reaching overflow without refresh asserts internal reset request
// - three-bit overflow select field in option byte, ascending codes
// - option bits 6 and 5 select window open period
// - standby bit 0 stops counter during halt, stop or snooze
// - standby bit 0 forces window open period to 100%
//
`timescale 1ns/10ps
`include "wdt_regs.vh"
module wdt_watchdog (
   input  wire        clock,
   input  wire        rst_b,
   input  wire [7:0]  option_byte,
   input  wire        slow_osc_clock,
   input  wire        standby_mode,
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [31:0] reg_rdata,
   output reg         wdt_reset_req,
   output reg         wdt_reset_window,
   output reg         interval_irq
);
   localparam PH_WATCH = 3'b001;
   localparam PH_OVF   = 3'b010;
   localparam PH_ABN   = 3'b100;

   reg  [7:0]  option_q;
   reg  [16:0] count;
   reg  [16:0] next_count;
   reg         slow_prev;
   reg         irq_en;
   reg         interval_done;
   reg         next_interval_done;
   reg         interval_flag;
   reg         interval_hit;
   reg  [16:0] ovf_lim;
   reg  [16:0] open_from;
   reg  [1:0]  win_sel;
   reg  [2:0]  phase;
   reg  [2:0]  next_phase;
   reg  [31:0] status_word;
   reg  [31:0] next_rdata;
   reg         counting;
   reg         window_open;
   reg         key_write;
   reg         refresh_ok;
   reg         refresh_bad;
   reg         at_overflow;
   wire        slow_sync;
   wire        standby_sync;
   wire        slow_rise;
   wire        slow_fall;
   wire        run_enable;
   wire        stby_run;
   wire        tick;
   wire [16:0] three_quarter;
   wire [2:0]  ovf_sel;

   // both pins are outside the clock domain
   wdt_sync u_slow_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .async_in (slow_osc_clock),
      .sync_out (slow_sync)
   );

   wdt_sync u_stby_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .async_in (standby_mode),
      .sync_out (standby_sync)
   );

   always @(posedge clock) begin
      if (!rst_b) begin
         slow_prev <= 1'b0;
      end else begin
         slow_prev <= slow_sync;
      end
   end

   // edges of the slow clock become one-cycle enables
   assign slow_rise = slow_sync & ~slow_prev;
   assign slow_fall = ~slow_sync & slow_prev;

   // option byte is loaded while reset is held, frozen afterwards
   always @(posedge clock) begin
      if (!rst_b) begin
         option_q <= option_byte;
      end
   end

   assign run_enable = option_q[`WDT_OPT_RUN_BIT];
   assign stby_run   = option_q[`WDT_OPT_STBY_BIT];
   assign ovf_sel    = option_q[`WDT_OPT_OVF_HI:`WDT_OPT_OVF_LO];

   always @* begin
      case (ovf_sel)
         3'h0:    ovf_lim = `WDT_OVF_LIM0;
         3'h1:    ovf_lim = `WDT_OVF_LIM1;
         3'h2:    ovf_lim = `WDT_OVF_LIM2;
         3'h3:    ovf_lim = `WDT_OVF_LIM3;
         3'h4:    ovf_lim = `WDT_OVF_LIM4;
         3'h5:    ovf_lim = `WDT_OVF_LIM5;
         3'h6:    ovf_lim = `WDT_OVF_LIM6;
         default: ovf_lim = `WDT_OVF_LIM7;
      endcase
   end

   // window forced fully open whenever the standby bit is 0, in or out of standby
   always @* begin
      if (!stby_run) begin
         win_sel = `WDT_WIN_100;
      end else begin
         win_sel = option_q[`WDT_OPT_WIN_HI:`WDT_OPT_WIN_LO];
      end
   end

   // open part sits at the end of each period
   always @* begin
      case (win_sel)
         `WDT_WIN_50: open_from = ovf_lim >> 1;
         `WDT_WIN_75: open_from = ovf_lim >> 2;
         default:     open_from = 17'h00000;
      endcase
   end

   assign three_quarter = ovf_lim - (ovf_lim >> 2);

   // stopped in low-power modes only when standby bit is 0
   always @* begin
      counting = run_enable & ~wdt_reset_req;
      if (standby_sync & ~stby_run) begin
         counting = 1'b0;
      end
   end

   assign tick = counting & slow_rise;

   // a tripped watchdog ignores further keys until system reset
   always @* begin
      window_open = (count >= open_from);
      key_write   = 1'b0;
      if (reg_write & (reg_addr == `WDT_OFS_KEY)) begin
         key_write = (reg_wdata[7:0] == `WDT_KEY_VALUE);
      end
      refresh_ok  = 1'b0;
      refresh_bad = 1'b0;
      if (key_write & run_enable & ~wdt_reset_req) begin
         refresh_ok  = window_open;
         refresh_bad = ~window_open;
      end
      at_overflow = tick & ((count + 17'h00001) == ovf_lim);
   end

   always @* begin
      next_count = count;
      if (refresh_ok) begin
         next_count = 17'h00000;
      end else if (tick) begin
         next_count = count + 17'h00001;
      end
   end

   always @(posedge clock) begin
      if (!rst_b) begin
         count <= 17'h00000;
      end else begin
         count <= next_count;
      end
   end

   // one-hot trip phase; the request holds until the system reset answers it
   always @* begin
      next_phase = phase;
      case (phase)
         PH_WATCH: begin
            if (refresh_bad) begin
               next_phase = PH_ABN;
            end else if (at_overflow & ~refresh_ok) begin
               next_phase = PH_OVF;
            end
         end
         PH_OVF: begin
            next_phase = PH_OVF;
         end
         PH_ABN: begin
            next_phase = PH_ABN;
         end
         default: begin
            next_phase = PH_WATCH;
         end
      endcase
   end

   always @(posedge clock) begin
      if (!rst_b) begin
         phase            <= PH_WATCH;
         wdt_reset_req    <= 1'b0;
         wdt_reset_window <= 1'b0;
      end else begin
         phase            <= next_phase;
         wdt_reset_req    <= (next_phase != PH_WATCH);
         wdt_reset_window <= (next_phase == PH_ABN);
      end
   end

   // interval fires on the falling edge after the 75% point: half a period later
   always @* begin
      interval_hit = counting & slow_fall & ~interval_done & ~refresh_ok
                     & (count >= three_quarter);
      next_interval_done = interval_done;
      if (refresh_ok) begin
         next_interval_done = 1'b0;
      end else if (interval_hit) begin
         next_interval_done = 1'b1;
      end
   end

   always @(posedge clock) begin
      if (!rst_b) begin
         interval_done <= 1'b0;
      end else begin
         interval_done <= next_interval_done;
      end
   end

   always @(posedge clock) begin
      if (!rst_b) begin
         interval_irq <= 1'b0;
      end else begin
         interval_irq <= interval_hit & irq_en;
      end
   end

   // set wins over a clear in the same cycle
   always @(posedge clock) begin
      if (!rst_b) begin
         interval_flag <= 1'b0;
      end else if (interval_hit) begin
         interval_flag <= 1'b1;
      end else if (reg_write & (reg_addr == `WDT_OFS_STATUS)
                   & reg_wdata[`WDT_ST_INTERVAL]) begin
         interval_flag <= 1'b0;
      end
   end

   always @(posedge clock) begin
      if (!rst_b) begin
         irq_en <= `WDT_CTL_IRQ_RST;
      end else if (reg_write & (reg_addr == `WDT_OFS_CONTROL)) begin
         irq_en <= reg_wdata[`WDT_CTL_IRQ_EN];
      end
   end

   always @* begin
      status_word                    = 32'h00000000;
      status_word[`WDT_ST_RUNNING]   = counting;
      status_word[`WDT_ST_WIN_OPEN]  = window_open;
      status_word[`WDT_ST_ABNORMAL]  = wdt_reset_window;
      status_word[`WDT_ST_OVERFLOW]  = wdt_reset_req;
      status_word[`WDT_ST_INTERVAL]  = interval_flag;
   end

   always @* begin
      next_rdata = 32'h00000000;
      if (reg_read) begin
         case (reg_addr)
            `WDT_OFS_COUNT:   next_rdata = {15'h0000, count};
            `WDT_OFS_STATUS:  next_rdata = status_word;
            `WDT_OFS_CONTROL: next_rdata = {31'h00000000, irq_en};
            `WDT_OFS_OPTION:  next_rdata = {24'h000000, option_q};
            default:          next_rdata = 32'h00000000;
         endcase
      end
   end

   // read data stand only in the cycle after the strobe
   always @(posedge clock) begin
      if (!rst_b) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= next_rdata;
      end
   end
endmodule // wdt_watchdog

// file: test/wdt_props.sv
`timescale 1ns/10ps
module wdt_props (
   input logic        clock,
   input logic        rst_b,
   input logic [7:0]  option_byte,
   input logic [7:0]  reg_addr,
   input logic [31:0] reg_wdata,
   input logic        reg_write,
   input logic        reg_read,
   input logic [31:0] reg_rdata,
   input logic        wdt_reset_req,
   input logic        wdt_reset_window,
   input logic        interval_irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   AST_REQ_HOLD: assert property (wdt_reset_req |=> wdt_reset_req)
      else $error("reset request dropped");
   AST_WIN_HOLD: assert property (wdt_reset_window |=> wdt_reset_window)
      else $error("window flag dropped");
   AST_WIN_REQ: assert property (wdt_reset_window |-> wdt_reset_req)
      else $error("window flag without request");
   AST_WIN_KEY: assert property ($rose(wdt_reset_window) |->
      $past(reg_write && reg_addr == 8'h00 && reg_wdata[7:0] == 8'hAC))
      else $error("window flag without key write");
   AST_IRQ_PULSE: assert property (interval_irq |=> !interval_irq)
      else $error("interval pulse too long");
   AST_OFF_QUIET: assert property (!option_byte[4] |-> !wdt_reset_req && !interval_irq)
      else $error("disabled watchdog active");
   AST_CNT_WIDTH: assert property ($past(reg_read && reg_addr == 8'h04) |->
      reg_rdata[31:17] == 15'h0)
      else $error("count wider than 17 bits");
   AST_OPT_READ: assert property ($past(reg_read && reg_addr == 8'h10) |->
      reg_rdata == {24'h0, option_byte})
      else $error("option readback wrong");
   cover property ($rose(wdt_reset_req) && !wdt_reset_window);
   cover property ($rose(wdt_reset_window));
   cover property (interval_irq);
endmodule // wdt_props
bind wdt_watchdog wdt_props u_wdt_props (.clock(clock), .rst_b(rst_b),
   .option_byte(option_byte), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .wdt_reset_req(wdt_reset_req), .wdt_reset_window(wdt_reset_window),
   .interval_irq(interval_irq));

// file: test/tb_top.sv
`timescale 1ns/10ps
`include "wdt_regs.vh"
module tb_top;
   logic        clock, rst_b, slow_osc_clock, standby_mode, reg_write, reg_read, o;
   logic [7:0]  option_byte, reg_addr;
   logic [31:0] reg_wdata, q, r, w;
   logic [2:0]  sc = 3'h0;
   logic [16:0] lim;
   wire  [31:0] reg_rdata;
   wire         wdt_reset_req, wdt_reset_window, interval_irq;
   integer      errors, checks, seed, irqs, i, n, thr;
   wdt_watchdog u_wdt_watchdog (.clock(clock), .rst_b(rst_b), .option_byte(option_byte),
      .slow_osc_clock(slow_osc_clock), .standby_mode(standby_mode), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .wdt_reset_req(wdt_reset_req),
      .wdt_reset_window(wdt_reset_window), .interval_irq(interval_irq));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // slow clock of 8 system periods keeps overflow runs short
   always @(posedge clock) begin
      sc <= sc + 3'h1;
      slow_osc_clock <= sc[2];
      if (!rst_b) irqs <= 0;
      else if (interval_irq === 1'b1) irqs <= irqs + 1;
   end
   function logic [16:0] lim_of(input logic [2:0] cd);
      case (cd)
         3'h0: lim_of = 17'h00040;
         3'h1: lim_of = 17'h00080;
         3'h2: lim_of = 17'h00100;
         3'h3: lim_of = 17'h00200;
         3'h4: lim_of = 17'h00800;
         3'h5: lim_of = 17'h02000;
         3'h6: lim_of = 17'h04000;
         default: lim_of = 17'h10000;
      endcase
   endfunction
   function logic [7:0] ob(input logic [2:0] cd, input logic [1:0] wn, input logic sb);
      ob = {1'b0, wn, 1'b1, cd, sb};
   endfunction
   // first open count; codes 00 and 11 and standby 0 mean always open
   function integer open_at(input logic [1:0] wn, input logic sb);
      if (!sb || wn == 2'h0 || wn == 2'h3) open_at = 0;
      else if (wn == 2'h1) open_at = 32;
      else open_at = 16;
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks = checks + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task close_out;
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task start(input logic [7:0] opt);
      @(posedge clock);
      rst_b <= 1'b0;
      option_byte <= opt;
      repeat (10) @(posedge clock);
      rst_b <= 1'b1;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] dat);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= dat;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   initial begin
      rst_b = 1'b0;
      standby_mode = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      option_byte = 8'h00;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      errors = 0;
      checks = 0;
      seed = 59695;
      start(8'h00);
      repeat (200) @(posedge clock);
      rd(`WDT_OFS_COUNT, q);
      chk(q, 32'h0);
      for (i = 0; i < 5; i = i + 1) begin
         lim = lim_of(i[2:0]);
         start(ob(i[2:0], 2'h3, 1'b1));
         rd(`WDT_OFS_OPTION, q);
         chk(q, {24'h0, ob(i[2:0], 2'h3, 1'b1)});
         wr(`WDT_OFS_CONTROL, 32'h1);
         n = 0;
         while (wdt_reset_req !== 1'b1 && n < 8 * lim + 100) begin
            @(posedge clock);
            n = n + 1;
         end
         if (n >= 8 * lim + 100) begin
            errors = errors + 1;
            close_out;
         end
         chk(n > 8 * lim - 20 && n < 8 * lim + 20, 1);
         rd(`WDT_OFS_COUNT, q);
         chk(q, lim);
         chk(irqs, 1);
         rd(`WDT_OFS_STATUS, q);
         chk(q, 32'h1A);
      end
      // random key timing against every window code, standby bit random
      for (i = 0; i < 24; i = i + 1) begin
         w = $random(seed);
         start(ob(3'h0, w[1:0], w[2]));
         repeat (w[12:4] % 470) @(posedge clock);
         rd(`WDT_OFS_COUNT, q);
         thr = open_at(w[1:0], w[2]);
         o = q >= thr;
         wr(`WDT_OFS_KEY, {24'h0, `WDT_KEY_VALUE});
         rd(`WDT_OFS_COUNT, r);
         // count may tick between read and key, so the edge value is skipped
         if (q != thr - 1) begin
            chk(wdt_reset_window, !o);
            if (o) chk(r < 2, 1);
         end
      end
      start(ob(3'h3, 2'h3, 1'b0));
      standby_mode <= 1'b1;
      repeat (40) @(posedge clock);
      rd(`WDT_OFS_COUNT, q);
      repeat (80) @(posedge clock);
      rd(`WDT_OFS_COUNT, r);
      chk(r, q);
      standby_mode <= 1'b0;
      repeat (80) @(posedge clock);
      rd(`WDT_OFS_COUNT, r);
      chk(r > q, 1);
      close_out;
   end
endmodule // tb_top
